// ### rtl/daisy_chain_spi_register_port.sv
// Daisy-chain serial register port: serial shift path and register file.
`timescale 1ns/1ps
// Overview of operation
// - Serial clock and data are ignored whenever chip select is high.
// - Each rising serial clock edge while selected shifts the input into 16 bits.
// - Serial output stays low while deselected; no clock or data accepted then.
// - Serial output takes the next shift bit after every falling clock edge.
// - The shifted frame moves into the registers when chip select rises.
// - While selected the port only shifts; decoding waits for chip select rising.
// - Shift path loads from input and unloads to output on the same clock.
// - Frame bits 15..9 address, bit 8 read when one, bits 7..0 data.
// - Fewer than sixteen bits before select rises write no register; one to fifteen pulse short_frame.
// - Read decoded at select rise, data preloaded and shifted out next selection.
// - Returned read frame holds a don't-care upper byte then the register byte.
// - Frames sent during retrieval execute at the next select rise.
// - Reset clears the frame handling state and all registers to zero.

module daisy_chain_spi_register_port (
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       sdi,
	output logic            sdo,
	input  wire logic [6:0] lookup_addr,
	output logic      [7:0] lookup_data,
	output logic            wr_strobe,
	output logic      [6:0] wr_addr,
	output logic      [7:0] wr_data,
	output logic            short_frame
);

	// ****************************************************************
	// Serial clock domain
	// ****************************************************************
	logic [spi_chain_pkg::FRAME_BITS-1:0] shift_reg;
	logic [spi_chain_pkg::FRAME_BITS-1:0] next_shift;
	logic [spi_chain_pkg::COUNT_BITS-1:0] bit_count;
	logic [spi_chain_pkg::FRAME_BITS-1:0] preload;
	wire                                  first_bit;

	assign first_bit  = (bit_count == spi_chain_pkg::COUNT_ZERO);
	// The first edge of a selection replaces the old frame with the preloaded
	// answer, so the answer leaves on the output while new bits arrive.
	assign next_shift = first_bit ?
		{preload[spi_chain_pkg::SHIFT_MSB-1:0], sdi} :
		{shift_reg[spi_chain_pkg::SHIFT_MSB-1:0], sdi};

	// Chip select high is the frame's own end: it clears the count without
	// needing a serial clock edge, which the master stops outside frames.
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_count <= spi_chain_pkg::COUNT_ZERO;
		end else if (bit_count != spi_chain_pkg::COUNT_FULL) begin
			bit_count <= bit_count + spi_chain_pkg::COUNT_ONE;
		end
	end

	always_ff @(posedge sclk) begin
		if (!cs_n) begin
			shift_reg <= next_shift;
		end
	end

	// The upper byte of the answer leaves first and is don't-care, so its
	// first bit may be the low level held from deselection.
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			sdo <= 1'b0;
		end else begin
			sdo <= shift_reg[spi_chain_pkg::SHIFT_MSB];
		end
	end

	// ****************************************************************
	// Chip select crossing into the core clock
	// ****************************************************************
	logic cs_meta;
	logic cs_sync;
	logic cs_prev;
	wire  frame_take;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			cs_prev <= 1'b1;
		end else begin
			cs_meta <= cs_n;
			cs_sync <= cs_meta;
			cs_prev <= cs_sync;
		end
	end

	// Shift path and captured count are static once select is high, so they are read
	// here only after the synchronised select edge has arrived.
	assign frame_take = cs_sync && !cs_prev;

	// ****************************************************************
	// Frame decoding
	// ****************************************************************
	// The count is taken on the rising select edge itself. The clear that the
	// same edge starts is a non-blocking update, so the capture sees the count
	// of the frame that just ended; in silicon this leans on the capture flop's
	// hold time being shorter than the counter's reset path.
	logic [spi_chain_pkg::COUNT_BITS-1:0] end_count;

	always_ff @(posedge cs_n) begin
		end_count <= bit_count;
	end

	// ****************************************************************
	// Frame handling state
	// ****************************************************************
	spi_chain_pkg::port_state_e state;
	spi_chain_pkg::port_state_e next_state;

	// Decode lasts one cycle per selection, so a select line that stays high
	// never replays the last frame into the registers.
	always_comb begin
		next_state = state;
		case (state)
			spi_chain_pkg::PORT_IDLE: begin
				if (!cs_sync) begin
					next_state = spi_chain_pkg::PORT_SHIFT;
				end
			end
			spi_chain_pkg::PORT_SHIFT: begin
				if (frame_take) begin
					next_state = spi_chain_pkg::PORT_DECODE;
				end
			end
			spi_chain_pkg::PORT_DECODE: begin
				next_state = spi_chain_pkg::PORT_IDLE;
			end
			default: begin
				next_state = spi_chain_pkg::PORT_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state <= spi_chain_pkg::PORT_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// Frame fields
	// ****************************************************************
	wire                                 frame_full;
	wire                                 frame_nop;
	wire                                 frame_read;
	wire [spi_chain_pkg::ADDR_BITS-1:0]  frame_addr;
	wire [spi_chain_pkg::DATA_BITS-1:0]  frame_data;
	wire [spi_chain_pkg::DATA_BITS-1:0]  rd_byte;
	wire                                 decode_now;
	wire                                 frame_short;
	wire                                 do_write;
	wire                                 do_read;

	assign frame_full  = (end_count == spi_chain_pkg::COUNT_FULL);
	assign frame_short = (end_count != spi_chain_pkg::COUNT_ZERO) && !frame_full;
	assign frame_nop   = spi_chain_pkg::is_nop(shift_reg);
	assign frame_addr  = shift_reg[spi_chain_pkg::ADDR_MSB:spi_chain_pkg::ADDR_LSB];
	assign frame_read  = (shift_reg[spi_chain_pkg::RW_BIT] == spi_chain_pkg::ACCESS_READ);
	assign frame_data  = shift_reg[spi_chain_pkg::DATA_MSB:spi_chain_pkg::DATA_LSB];
	assign decode_now  = (state == spi_chain_pkg::PORT_DECODE);
	assign do_write    = decode_now && frame_full && !frame_nop && !frame_read;
	assign do_read     = decode_now && frame_full && !frame_nop && frame_read;

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [spi_chain_pkg::DATA_BITS-1:0] regs [spi_chain_pkg::REG_COUNT];

	// One process per entry keeps each write enable a single compare and lets
	// reset clear the whole file in one cycle.
	genvar reg_index;
	generate
		for (reg_index = 0; reg_index < spi_chain_pkg::REG_COUNT; reg_index++) begin : reg_slot
			localparam logic [spi_chain_pkg::ADDR_BITS-1:0] SLOT_ADDR =
				(spi_chain_pkg::ADDR_BITS)'(reg_index);
			wire slot_hit;

			assign slot_hit = do_write && (frame_addr == SLOT_ADDR);

			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					regs[reg_index] <= spi_chain_pkg::REG_RESET;
				end else if (slot_hit) begin
					regs[reg_index] <= frame_data;
				end
			end
		end
	endgenerate

	assign rd_byte = regs[frame_addr];

	// ****************************************************************
	// Answer for the next selection
	// ****************************************************************
	wire [spi_chain_pkg::FRAME_BITS-1:0] next_preload;

	// Frames that are not reads leave again with bit 15 replaced by the held low level,
	// so a device inside a chain passes its neighbours' frames along on the next selection.
	assign next_preload = do_read ? {spi_chain_pkg::UPPER_FILL, rd_byte} : shift_reg;

	// The serial side reads this word at the first clock edge of the next
	// selection with no synchroniser. That is safe only because the master
	// keeps select high for at least eight core clock periods between frames.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			preload <= spi_chain_pkg::PRELOAD_RST;
		end else if (decode_now) begin
			preload <= next_preload;
		end
	end

	// ****************************************************************
	// Core side outputs
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wr_strobe   <= 1'b0;
			short_frame <= 1'b0;
		end else begin
			wr_strobe   <= do_write;
			short_frame <= decode_now && frame_short;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wr_addr <= 7'h00;
			wr_data <= 8'h00;
		end else if (do_write) begin
			wr_addr <= frame_addr;
			wr_data <= frame_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			lookup_data <= 8'h00;
		end else begin
			lookup_data <= regs[lookup_addr];
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	// A write decode excludes the other two kinds; a short frame can also be all ones.
	sequence write_decode_s;
		decode_now && frame_full && !frame_nop && !frame_read;
	endsequence

	sequence nop_decode_s;
		decode_now && frame_nop;
	endsequence

	sequence short_decode_s;
		decode_now && frame_short;
	endsequence

	// Properties clock on the core side; the serial side is watched through what it
	// leaves standing once select is high, and through the bit count at every edge.
	property write_follows_p;
		@(posedge core_clk) disable iff (!rstn)
		write_decode_s |=> wr_strobe && (regs[wr_addr] == wr_data);
	endproperty

	property strobe_pulse_p;
		@(posedge core_clk) disable iff (!rstn)
		wr_strobe |=> !wr_strobe;
	endproperty

	property nop_quiet_p;
		@(posedge core_clk) disable iff (!rstn)
		nop_decode_s |=> !wr_strobe;
	endproperty

	property short_flag_p;
		@(posedge core_clk) disable iff (!rstn)
		short_decode_s |=> short_frame && !wr_strobe;
	endproperty

	property sdo_idle_p;
		@(posedge core_clk) disable iff (!rstn)
		cs_n |-> !sdo;
	endproperty

	property count_ceiling_p;
		@(posedge core_clk) disable iff (!rstn)
		bit_count <= spi_chain_pkg::COUNT_FULL;
	endproperty

	property select_quiet_p;
		@(posedge core_clk) disable iff (!rstn)
		!cs_sync |-> !decode_now;
	endproperty

	property read_answer_p;
		@(posedge core_clk) disable iff (!rstn)
		do_read |=> (preload == {spi_chain_pkg::UPPER_FILL, $past(rd_byte)});
	endproperty

	property state_reset_p;
		@(posedge core_clk)
		!rstn |=> (state == spi_chain_pkg::PORT_IDLE);
	endproperty

	write_decode_a: assert property (write_follows_p)
		else $error("Decoded write did not reach the register file");

	strobe_pulse_a: assert property (strobe_pulse_p)
		else $error("Write strobe stood longer than one cycle");

	nop_quiet_a: assert property (nop_quiet_p)
		else $error("All-ones frame caused a write");

	short_flag_a: assert property (short_flag_p)
		else $error("Short frame was not flagged or caused a write");

	sdo_idle_a: assert property (sdo_idle_p)
		else $error("Serial output not low while deselected");

	count_ceiling_a: assert property (count_ceiling_p)
		else $error("Bit count passed the frame length");

	select_quiet_a: assert property (select_quiet_p)
		else $error("Frame decoded while selected");

	read_answer_a: assert property (read_answer_p)
		else $error("Read answer not preloaded");

	state_reset_a: assert property (state_reset_p)
		else $error("Frame state not idle after reset");

endmodule : daisy_chain_spi_register_port

// ### pkg/spi_chain_pkg.sv
// Constants shared by the daisy-chain serial register port.
package spi_chain_pkg;

	// ****************************************************************
	// Frame layout
	// ****************************************************************
	localparam int          FRAME_BITS  = 16;
	localparam int          ADDR_BITS   = 7;
	localparam int          DATA_BITS   = 8;
	localparam int          ADDR_MSB    = 15;
	localparam int          ADDR_LSB    = 9;
	localparam int          RW_BIT      = 8;
	localparam int          DATA_MSB    = 7;
	localparam int          DATA_LSB    = 0;
	localparam int          SHIFT_MSB   = 15;
	localparam logic [15:0] NOP_FRAME   = 16'hFFFF;
	localparam logic        ACCESS_READ = 1'b1;

	// ****************************************************************
	// Bit counter and register file
	// ****************************************************************
	localparam int          COUNT_BITS  = 5;
	localparam logic [4:0]  COUNT_ZERO  = 5'h00;
	localparam logic [4:0]  COUNT_ONE   = 5'h01;
	localparam logic [4:0]  COUNT_FULL  = 5'h10;
	localparam int          REG_COUNT   = 128;
	localparam logic [7:0]  REG_RESET   = 8'h00;
	localparam logic [7:0]  UPPER_FILL  = 8'h00;
	localparam logic [15:0] PRELOAD_RST = 16'h0000;

	// ****************************************************************
	// Frame handling states
	// ****************************************************************
	typedef enum logic [1:0] {
		PORT_IDLE    = 2'b00,
		PORT_SHIFT   = 2'b01,
		PORT_DECODE  = 2'b11
	} port_state_e;

	// All ones is a no-operation frame that writes no register.
	function automatic logic is_nop(input logic [15:0] frame);
		is_nop = (frame == NOP_FRAME);
	endfunction : is_nop

endpackage : spi_chain_pkg

// ### dv/spi_master_model.sv
// Serial master model that drives whole or partial frames into the port.
`timescale 1ns/1ps
module spi_master_model (
	output logic      sclk,
	output logic      cs_n,
	output logic      sdi,
	input  wire logic sdo
);
	logic [15:0] rx;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi  = 1'b0;
	end
	// The clock stands still between frames; a short count leaves a partial frame.
	task automatic xfer(input logic [15:0] tx, input int nbits);
		cs_n = 1'b0;
		for (int i = 15; i > 15 - nbits; i--) begin
			sdi = tx[i];
			#15 sclk = 1'b1;
			rx = {rx[14:0], sdo};
			#15 sclk = 1'b0;
		end
		#15 sdi = ~sdi;
		cs_n = 1'b1;
		#200;
	endtask : xfer
endmodule : spi_master_model

// ### dv/tb_daisy_chain_spi_register_port.sv
// Self-checking bench for the daisy-chain serial register port.
`timescale 1ns/1ps
module tb_daisy_chain_spi_register_port;
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [6:0]  lookup_addr = 7'h00;
	logic        sclk, cs_n, sdi, sdo, wr_strobe, short_frame;
	logic [7:0]  lookup_data, wr_data;
	logic [6:0]  wr_addr;
	int          n_errors = 0;
	int          check_count = 0;
	int          cycles = 0;
	int          strobes = 0;
	int          shorts = 0;
	logic [14:0] last_wr = 15'h0000;
	logic [14:0] rows [4] = '{15'h00A5, 15'h7F3C, 15'h15FF, 15'h2A01};
	daisy_chain_spi_register_port daisy_chain_spi_register_port_inst (.core_clk(core_clk),
		.rstn(rstn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
		.lookup_addr(lookup_addr), .lookup_data(lookup_data), .wr_strobe(wr_strobe),
		.wr_addr(wr_addr), .wr_data(wr_data), .short_frame(short_frame));
	spi_master_model spi_master_model_inst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (wr_strobe === 1'b1) strobes <= strobes + 1;
		if (wr_strobe === 1'b1) last_wr <= {wr_addr, wr_data};
		if (short_frame === 1'b1) shorts <= shorts + 1;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic peek(input logic [6:0] a, input logic [7:0] exp);
		@(negedge core_clk) lookup_addr = a;
		repeat (8) @(negedge core_clk);
		check("lookup_data", exp, lookup_data);
	endtask : peek
	task automatic finish_test();
		if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test
	initial begin
		repeat (10) @(negedge core_clk);
		rstn = 1'b1;
		peek(7'h15, 8'h00);
		foreach (rows[i]) begin
			spi_master_model_inst.xfer({rows[i][14:8], 1'b0, rows[i][7:0]}, 16);
			peek(rows[i][14:8], rows[i][7:0]);
		end
		check("wr_strobe count", 8'h04, 8'(strobes));
		check("wr_addr", 8'h2A, {1'b0, last_wr[14:8]});
		check("wr_data", 8'h01, last_wr[7:0]);
		spi_master_model_inst.xfer({7'h00, 1'b0, 8'h77}, 12);
		peek(7'h00, 8'hA5);
		check("short_frame count", 8'h01, 8'(shorts));
		spi_master_model_inst.xfer(16'hFFFF, 16);
		peek(7'h7F, 8'h3C);
		check("wr_strobe count", 8'h04, 8'(strobes));
		spi_master_model_inst.xfer({7'h00, 1'b1, 8'hFF}, 16);
		spi_master_model_inst.xfer({7'h2A, 1'b0, 8'hC3}, 16);
		check("read data", 8'hA5, spi_master_model_inst.rx[7:0]);
		peek(7'h2A, 8'hC3);
		rstn = 1'b0;
		repeat (10) @(negedge core_clk);
		rstn = 1'b1;
		peek(7'h2A, 8'h00);
		spi_master_model_inst.xfer(16'hFFFF, 16);
		check("answer after reset", 8'h00, spi_master_model_inst.rx[7:0]);
		check("sdo idle", 8'h00, {7'h00, sdo});
		finish_test();
	end
endmodule : tb_daisy_chain_spi_register_port
